// ===== core/agc_core.sv
// Summary of operation
// - Offset is base plus scaled index plus displacement.
// - Index scale is 1, 2, 4 or 8 as a left shift.
// - Base and index from any register; index is signed.
// - Displacement of 8, 16 or 32 bits is sign-extended.
// - Long mode produces 64-bit segment offsets.
// - Linear address is segment base plus offset.
// - Flat model and 64-bit mode use a zero segment base.
// - With paging off the linear address is the physical address.
// - Protected mode virtual addresses are 32 bits wide.
// - Long mode virtual addresses are 64 bits wide.
// - Real mode physical addresses are 21 bits wide; bit 20 holds the carry unless masked.
// - Legacy protected mode physical addresses are 32 bits wide.
// - Extension enabled lets paging reach 52-bit physical addresses.
// - Long mode allowed only with paging and the extension on.
// - Bits 63 down to top implemented bit must be all equal.
// - Non-canonical reference raises a general protection fault.
// - Non-canonical implied stack reference raises a stack fault.
// - Push, pop and stack or frame based accesses are stack refs.
// - Every long mode linear address is checked for canonical form.
// - Real mode is selectable from any mode, long mode included.
// - Selector picks one entry of global or local table.
// - Real mode base is selector shifted left four bits.
// - Asserted bit-20 mask forces address bit 20 to zero in real mode only.
// - 64-bit mode ignores the segment limit.
`timescale 1ns/1ps
`default_nettype none
module agc_core (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire agc_pkg::agc_req_s req,
  input  wire logic              address_bit20_mask_n,
  output var  agc_pkg::agc_res_s res,
  input  wire logic [4:0]        s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [4:0]        s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  typedef struct packed {
    agc_pkg::agc_mode_e mode;
    logic               paging;
    logic               phys_addr_extension;
    logic               st_gp;
    logic               st_ss;
    logic               st_rej;
    logic [63:0]        faddr;
    logic [31:0]        fcount;
    logic               aw_held;
    logic [4:0]         aw_addr;
    logic               w_held;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    agc_pkg::agc_res_s  res;
  } agc_state_s;

  agc_state_s s_q;
  agc_state_s s_d;

  // Sign-extend the displacement by its encoded size
  function automatic logic [63:0] disp_ext(agc_pkg::agc_dsp_e sz,
                                           logic [31:0] d);
    case (sz)
      agc_pkg::DSP_8:  disp_ext = {{56{d[7]}}, d[7:0]};
      agc_pkg::DSP_16: disp_ext = {{48{d[15]}}, d[15:0]};
      agc_pkg::DSP_32: disp_ext = {{32{d[31]}}, d};
      default:         disp_ext = 64'h0;
    endcase
  endfunction

  // Byte-lane merge for a 32-bit register write
  function automatic logic [31:0] lane_merge(logic [31:0] old,
                                             logic [31:0] nw,
                                             logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    lane_merge = r;
  endfunction

  logic [63:0] ea64;
  logic [63:0] lin;
  logic [63:0] phys;
  logic [20:0] real_sum;
  logic        canon_ok;
  logic        stack_ref;
  logic [15:0] top_bits;
  logic        do_wr;
  logic        ev_gp;
  logic        ev_ss;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic [31:0] wv;
  logic        wr_ctrl_ok;

  always_comb begin
    ea64 = (req.use_base ? req.base : 64'h0)
         + (req.use_index ? (req.index << req.scale_log2) : 64'h0)
         + disp_ext(req.disp_size, req.disp);
    real_sum = {1'b0, req.selector, 4'h0} + {5'h00, ea64[15:0]};
    if (!address_bit20_mask_n) begin
      real_sum[agc_pkg::A20_BIT] = 1'b0;
    end
    lin = 64'h0;
    case (s_q.mode)
      agc_pkg::MODE_REAL: begin
        lin = {43'h0, real_sum};
      end
      agc_pkg::MODE_LONG64: begin
        lin = ea64;
      end
      default: begin
        lin = {32'h0, req.seg_base[31:0] + ea64[31:0]};
      end
    endcase
    top_bits = lin[63:agc_pkg::VA_IMPL_BITS];
    canon_ok = (top_bits == 16'h0000 && !lin[agc_pkg::VA_IMPL_BITS-1])
            || (top_bits == 16'hffff && lin[agc_pkg::VA_IMPL_BITS-1]);
    stack_ref = req.push_pop
             || (req.use_base && (req.base_reg == agc_pkg::REG_STACK_PTR
             || req.base_reg == agc_pkg::REG_FRAME_BASE));
    ev_ss = req.valid && s_q.mode == agc_pkg::MODE_LONG64
         && !canon_ok && stack_ref;
    ev_gp = req.valid && s_q.mode == agc_pkg::MODE_LONG64
         && !canon_ok && !stack_ref;
    phys = lin;
    if (s_q.paging) begin
      if (s_q.mode == agc_pkg::MODE_PROT && !s_q.phys_addr_extension) begin
        phys = {32'h0, lin[31:0]};
      end
    end
  end

  assign do_wr = (s_q.aw_held || s_axi_awvalid)
              && (s_q.w_held || s_axi_wvalid) && !s_q.bvalid;
  assign wv = lane_merge(ctrl_rd, s_q.w_held ? s_q.w_data : s_axi_wdata,
                         s_q.w_held ? s_q.w_strb : s_axi_wstrb);
  assign ctrl_rd = {28'h0, s_q.phys_addr_extension, s_q.paging, s_q.mode};
  assign stat_rd = {29'h0, s_q.st_rej, s_q.st_ss, s_q.st_gp};
  assign wr_ctrl_ok = wv[1:0] != agc_pkg::MODE_LONG64
                   || (wv[agc_pkg::CTRL_PG_BIT] && wv[agc_pkg::CTRL_PAE_BIT]);

  always_comb begin
    logic [4:0]  wa;
    logic [31:0] rd;
    logic [1:0]  rr;
    s_d = s_q;
    wa = s_q.aw_held ? s_q.aw_addr : s_axi_awaddr;
    rd = 32'h0;
    rr = agc_pkg::RESP_OKAY;
    // Result pipeline
    s_d.res.valid = req.valid;
    s_d.res.offset = (s_q.mode == agc_pkg::MODE_LONG64) ? ea64
                   : (s_q.mode == agc_pkg::MODE_REAL)
                   ? {48'h0, ea64[15:0]} : {32'h0, ea64[31:0]};
    s_d.res.linear = lin;
    s_d.res.phys = phys;
    s_d.res.needs_paging = s_q.paging;
    s_d.res.table_local = s_q.mode != agc_pkg::MODE_REAL
                       && req.selector[2];
    s_d.res.desc_index = req.selector[15:3];
    s_d.res.general_protection_fault = ev_gp;
    s_d.res.stack_fault = ev_ss;
    if (s_axi_awvalid && !s_q.aw_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.w_held && !s_q.bvalid) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // Hardware sets win over software clears below
    if (do_wr) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = agc_pkg::RESP_OKAY;
      case (wa)
        agc_pkg::OFS_CTRL: begin
          if (wr_ctrl_ok) begin
            s_d.mode = agc_pkg::agc_mode_e'(wv[1:0]);
            s_d.paging = wv[agc_pkg::CTRL_PG_BIT];
            s_d.phys_addr_extension = wv[agc_pkg::CTRL_PAE_BIT];
          end else begin
            s_d.st_rej = 1'b1;
          end
        end
        agc_pkg::OFS_STATUS: begin
          if ((s_q.w_held ? s_q.w_strb[0] : s_axi_wstrb[0])) begin
            if ((s_q.w_held ? s_q.w_data[0] : s_axi_wdata[0])) begin
              s_d.st_gp = 1'b0;
            end
            if ((s_q.w_held ? s_q.w_data[1] : s_axi_wdata[1])) begin
              s_d.st_ss = 1'b0;
            end
            if ((s_q.w_held ? s_q.w_data[2] : s_axi_wdata[2])) begin
              s_d.st_rej = 1'b0;
            end
          end
        end
        agc_pkg::OFS_FADDR_LO, agc_pkg::OFS_FADDR_HI,
        agc_pkg::OFS_FCOUNT: begin
        end
        default: s_d.bresp = agc_pkg::RESP_SLVERR;
      endcase
    end
    if (ev_gp) begin
      s_d.st_gp = 1'b1;
    end
    if (ev_ss) begin
      s_d.st_ss = 1'b1;
    end
    if (ev_gp || ev_ss) begin
      s_d.faddr = lin;
      s_d.fcount = s_q.fcount + 32'h1;
    end
    // Read channel, one cycle to answer
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_q.rvalid) begin
      case (s_axi_araddr)
        agc_pkg::OFS_CTRL:     rd = ctrl_rd;
        agc_pkg::OFS_STATUS:   rd = stat_rd;
        agc_pkg::OFS_FADDR_LO: rd = s_q.faddr[31:0];
        agc_pkg::OFS_FADDR_HI: rd = s_q.faddr[63:32];
        agc_pkg::OFS_FCOUNT:   rd = s_q.fcount;
        default:               rr = agc_pkg::RESP_SLVERR;
      endcase
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = rr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.mode <= agc_pkg::agc_mode_e'(agc_pkg::CTRL_MODE_RST);
      s_q.paging <= agc_pkg::CTRL_PG_RST;
      s_q.phys_addr_extension <= agc_pkg::CTRL_PAE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign res = s_q.res;
  assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_held && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Assertions
  // protection fault
  a_gp_noncanon: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (req.valid && s_q.mode == agc_pkg::MODE_LONG64 && !canon_ok
     && !stack_ref) |=> res.general_protection_fault && !res.stack_fault)
    else $error("missing protection fault");
  a_ss_noncanon: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (req.valid && s_q.mode == agc_pkg::MODE_LONG64 && !canon_ok
     && req.push_pop) |=> res.stack_fault && !res.general_protection_fault)
    else $error("missing stack fault");
  a_canon_passes: assert property (
    @(posedge aclk) disable iff (!aresetn)
    res.general_protection_fault |->
    res.linear[63:47] != 17'h0 && res.linear[63:47] != 17'h1ffff)
    else $error("fault on canonical address");
  a_flat_long: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (req.valid && s_q.mode == agc_pkg::MODE_LONG64) |=>
    res.linear == res.offset)
    else $error("long mode linear differs from offset");
  a_phys_pass: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (res.valid && !res.needs_paging) |-> res.phys == res.linear)
    else $error("physical differs from linear");
  a_prot_width: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (req.valid && s_q.mode == agc_pkg::MODE_PROT) |=>
    res.linear[63:32] == 32'h0)
    else $error("protected address too wide");
  a_bit20_mask: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (req.valid && s_q.mode == agc_pkg::MODE_REAL && !address_bit20_mask_n)
    |=> res.linear[63:20] == 44'h0)
    else $error("bit 20 not masked");
  a_long_paging: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_q.mode == agc_pkg::MODE_LONG64 |-> s_q.paging && s_q.phys_addr_extension)
    else $error("long mode without paging");
  // scale shift
  // Top index bits fall off the 64-bit sum, so compare the kept ones
  a_scale_eight: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (req.valid && s_q.mode == agc_pkg::MODE_LONG64 && req.use_index
     && !req.use_base && req.disp_size == agc_pkg::DSP_NONE
     && req.scale_log2 == 2'h3)
    |=> res.offset == {$past(req.index[60:0]), 3'h0})
    else $error("scale factor wrong");
  a_fault_pair: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !(res.general_protection_fault && res.stack_fault))
    else $error("two faults at once");

  c_gp_seen: cover property (@(posedge aclk) disable iff (!aresetn)
    res.general_protection_fault);
  c_ss_seen: cover property (@(posedge aclk) disable iff (!aresetn)
    res.stack_fault);
  c_real_seen: cover property (@(posedge aclk) disable iff (!aresetn)
    res.valid && s_q.mode == agc_pkg::MODE_REAL);
  c_reject: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.st_rej));

endmodule // agc_core
`default_nettype wire

// ===== core/agc_pkg.sv
`default_nettype none
package agc_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL      = 5'h00;
  localparam logic [4:0] OFS_STATUS    = 5'h04;
  localparam logic [4:0] OFS_FADDR_LO  = 5'h08;
  localparam logic [4:0] OFS_FADDR_HI  = 5'h0c;
  localparam logic [4:0] OFS_FCOUNT    = 5'h10;

  // Control field positions
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_PG_BIT    = 2;
  localparam int CTRL_PAE_BIT   = 3;
  // Status field positions
  localparam int ST_GP_BIT      = 0;
  localparam int ST_SS_BIT      = 1;
  localparam int ST_REJ_BIT     = 2;

  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic       CTRL_PG_RST   = 1'b0;
  localparam logic       CTRL_PAE_RST  = 1'b0;

  // Widths per mode
  localparam int VA_IMPL_BITS  = 48;
  localparam int REAL_PA_BITS  = 20;
  localparam int LEG_PA_BITS   = 32;
  localparam int PAE_PA_BITS   = 52;
  localparam int A20_BIT       = 20;

  // Register numbers treated as stack references
  localparam logic [3:0] REG_STACK_PTR  = 4'h4;
  localparam logic [3:0] REG_FRAME_BASE = 4'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_REAL   = 2'b00,
    MODE_PROT   = 2'b01,
    MODE_COMPAT = 2'b10,
    MODE_LONG64 = 2'b11
  } agc_mode_e;

  typedef enum logic [1:0] {
    DSP_NONE = 2'b00,
    DSP_8    = 2'b01,
    DSP_16   = 2'b10,
    DSP_32   = 2'b11
  } agc_dsp_e;

  typedef struct packed {
    logic        valid;
    logic        use_base;
    logic [3:0]  base_reg;
    logic [63:0] base;
    logic        use_index;
    logic [63:0] index;
    logic [1:0]  scale_log2;
    agc_dsp_e    disp_size;
    logic [31:0] disp;
    logic        push_pop;
    logic [15:0] selector;
    logic [63:0] seg_base;
  } agc_req_s;

  typedef struct packed {
    logic        valid;
    logic [63:0] offset;
    logic [63:0] linear;
    logic [63:0] phys;
    logic        needs_paging;
    logic        table_local;
    logic [12:0] desc_index;
    logic        general_protection_fault;
    logic        stack_fault;
  } agc_res_s;

endpackage
`default_nettype wire

// ===== dv/address_generation_canonical_check_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module address_generation_canonical_check_tb;
  typedef struct packed {
    logic [63:0] off;
    logic [63:0] lin;
    logic [13:0] sel;
    logic        pg;
    logic [1:0]  flt;
  } agc_exp_s;
  logic              aclk, aresetn, mask_n;
  agc_pkg::agc_req_s nxt, req, r;
  agc_pkg::agc_res_s res;
  logic [4:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata, rs;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [1:0]        bresp, rresp, md;
  logic              pg;
  int                failures, n_compared;
  agc_exp_s          q[$];
  agc_exp_s          e_m;

  agc_req_src src (.aclk(aclk), .nxt(nxt), .req(req));
  agc_core dut (
    .aclk(aclk), .aresetn(aresetn), .req(req),
    .address_bit20_mask_n(mask_n), .res(res),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  initial aclk = 1'b0;
  always #2 aclk = ~aclk;

  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) rs = {rs[30:0], rs[31]^rs[21]^rs[1]^rs[0]};
    return rs;
  endfunction

  function automatic agc_pkg::agc_req_s mkreq();
    agc_pkg::agc_req_s x;
    logic [287:0]      w;
    w = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    x = w[251:0];
    x.valid = 1'b1;
    x.use_base = 1'b1;
    x.use_index = 1'b1;
    x.push_pop = 1'b0;
    return x;
  endfunction

  // Expected results from mode, paging, the bit-20 mask and the request alone
  function automatic agc_exp_s calc(input agc_pkg::agc_req_s x, input logic m);
    agc_exp_s    e;
    logic [63:0] d, ea;
    logic        nc, st;
    case (x.disp_size)
      agc_pkg::DSP_8:  d = {{56{x.disp[7]}}, x.disp[7:0]};
      agc_pkg::DSP_16: d = {{48{x.disp[15]}}, x.disp[15:0]};
      agc_pkg::DSP_32: d = {{32{x.disp[31]}}, x.disp};
      default:         d = 64'h0;
    endcase
    ea = (x.use_base ? x.base : 64'h0) + d
       + (x.use_index ? (x.index << x.scale_log2) : 64'h0);
    nc = !((&ea[63:47]) || !(|ea[63:47]));
    st = x.push_pop || (x.use_base && (x.base_reg == agc_pkg::REG_STACK_PTR
         || x.base_reg == agc_pkg::REG_FRAME_BASE));
    e.pg = pg;
    e.flt = 2'b00;
    e.sel = {x.selector[2], x.selector[15:3]};
    case (md)
      2'h0: begin
        e.off = {48'h0, ea[15:0]};
        e.lin = {44'h0, x.selector, 4'h0} + e.off;
        e.lin[20] = e.lin[20] & m;
        e.sel[13] = 1'b0;
      end
      2'h3: begin
        e.off = ea;
        e.lin = ea;
        e.flt = nc ? {st, !st} : 2'b00;
      end
      default: begin
        e.off = {32'h0, ea[31:0]};
        e.lin = {32'h0, x.seg_base[31:0] + ea[31:0]};
      end
    endcase
    return e;
  endfunction

  task automatic send(input agc_pkg::agc_req_s x, input logic m);
    q.push_back(calc(x, m));
    nxt <= x;
    mask_n <= m;
    @(posedge aclk);
  endtask

  task automatic idle(input int n);
    nxt.valid <= 1'b0;
    repeat (n) @(posedge aclk);
  endtask

  task automatic axw(input logic [4:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    `CHK("bresp", er, bresp)
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axr(input logic [4:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  always @(posedge aclk) begin
    if (res.valid === 1'b1) begin
      if (q.size() == 0) begin
        failures++;
        $display("[FAIL] res.valid exp 0 got 1");
      end else begin
        e_m = q.pop_front();
        `CHK("offset", e_m.off, res.offset)
        `CHK("linear", e_m.lin, res.linear)
        `CHK("phys", e_m.lin, res.phys)
        `CHK("sel", e_m.sel, {res.table_local, res.desc_index})
        `CHK("paging", e_m.pg, res.needs_paging)
        `CHK("faults", e_m.flt, {res.stack_fault,
              res.general_protection_fault})
      end
    end
  end

  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run is about 130 cycles; this leaves a wide margin
  initial begin
    #200000;
    failures++;
    summarize();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    nxt = '0;
    mask_n = 1'b1;
    rs = 32'hd18c5f0a;
    md = 2'h0;
    pg = 1'b0;
    failures = 0;
    n_compared = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(agc_pkg::OFS_CTRL, 32'h0, agc_pkg::RESP_OKAY);
    axr(agc_pkg::OFS_STATUS, 32'h0, agc_pkg::RESP_OKAY);
    axr(agc_pkg::OFS_FCOUNT, 32'h0, agc_pkg::RESP_OKAY);
    axr(5'h14, 32'h0, agc_pkg::RESP_SLVERR);
    axw(5'h18, 32'h1, agc_pkg::RESP_SLVERR);
    for (int m = 1; m >= 0; m--) begin
      for (int i = 0; i < 6; i++) begin
        r = mkreq();
        if (i[0]) r.selector = 16'hffff;
        send(r, m[0]);
      end
      idle(2);
    end
    for (int mm = 1; mm < 3; mm++) begin
      axw(agc_pkg::OFS_CTRL, mm, agc_pkg::RESP_OKAY);
      md = mm[1:0];
      for (int k = 0; k < 16; k++) begin
        r = mkreq();
        r.scale_log2 = k[1:0];
        r.disp_size = agc_pkg::agc_dsp_e'(k[3:2]);
        send(r, 1'b1);
      end
      idle(2);
    end
    axw(agc_pkg::OFS_CTRL, 32'h3, agc_pkg::RESP_OKAY);
    axr(agc_pkg::OFS_CTRL, 32'h2, agc_pkg::RESP_OKAY);
    axr(agc_pkg::OFS_STATUS, 32'h4, agc_pkg::RESP_OKAY);
    axw(agc_pkg::OFS_CTRL, 32'hf, agc_pkg::RESP_OKAY);
    md = 2'h3;
    pg = 1'b1;
    axr(agc_pkg::OFS_CTRL, 32'hf, agc_pkg::RESP_OKAY);
    for (int k = 0; k < 7; k++) begin
      r = mkreq();
      r.index = 64'h0;
      r.disp_size = agc_pkg::DSP_NONE;
      r.base_reg = 4'h0;
      case (k)
        0: r.base = {17'h1ffff, 15'h0, rnd()};
        1: r.base = {17'h0, 15'h7fff, rnd()};
        5: begin
          r.base = 64'h7fff_0000_0000_0000;
          r.push_pop = 1'b1;
        end
        6: begin
          r.use_base = 1'b0;
          r.scale_log2 = 2'h3;
          r.index = {32'h0, rnd()};
        end
        default: begin
          r.base = 64'h0000_8000_0000_0000;
          r.base_reg = (k == 2) ? 4'h0 : 4'(k + 1);
        end
      endcase
      send(r, 1'b1);
    end
    idle(3);
    axr(agc_pkg::OFS_FCOUNT, 32'h4, agc_pkg::RESP_OKAY);
    axr(agc_pkg::OFS_STATUS, 32'h7, agc_pkg::RESP_OKAY);
    axr(agc_pkg::OFS_FADDR_LO, 32'h0, agc_pkg::RESP_OKAY);
    axr(agc_pkg::OFS_FADDR_HI, 32'h7fff0000, agc_pkg::RESP_OKAY);
    axw(agc_pkg::OFS_STATUS, 32'h7, agc_pkg::RESP_OKAY);
    axr(agc_pkg::OFS_STATUS, 32'h0, agc_pkg::RESP_OKAY);
    summarize();
  end
endmodule // address_generation_canonical_check_tb
`undef CHK
`default_nettype wire

// ===== dv/agc_req_src.sv
`timescale 1ns/1ps
`default_nettype none
module agc_req_src (
  input  wire agc_pkg::agc_req_s nxt,
  input  wire logic              aclk,
  output var  agc_pkg::agc_req_s req
);
  // one-cycle requests
  // Released fields flip so a stale value never passes for a live one
  always_ff @(posedge aclk) begin
    if (nxt.valid) begin
      req <= nxt;
    end else begin
      req       <= ~req;
      req.valid <= 1'b0;
    end
  end
endmodule // agc_req_src
`default_nettype wire
